// ---- logic/char_lcd_pkg.sv ----
package char_lcd_pkg;

  // clock and oscillator rates
  localparam int CLK_PERIOD_NS   = 8;
  localparam int OSC_FREQ_KHZ    = 270;
  localparam int OSC_PERIOD_NS   = 1000000 / OSC_FREQ_KHZ;
  localparam int OSC_DIV_DEFAULT = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OSC_W           = 16;

  // execution times as printed, in ns
  localparam int T_CLEAR_NS = 1530000;
  localparam int T_CMD_NS   = 39000;
  localparam int T_DATA_NS  = 43000;

  // busy length in oscillator ticks, rounded up, plus one for tick phase
  localparam int BUSY_W = 9;
  localparam logic [BUSY_W-1:0] TICKS_LONG = BUSY_W'((T_CLEAR_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS + 1);
  localparam logic [BUSY_W-1:0] TICKS_CMD  = BUSY_W'((T_CMD_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS + 1);
  localparam logic [BUSY_W-1:0] TICKS_DATA = BUSY_W'((T_DATA_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS + 1);
  localparam logic [BUSY_W-1:0] TICKS_ONE  = 9'h001;

  // cursor blink half period
  localparam int BLINK_HALF_US       = 400000;
  localparam int BLINK_TICKS_DEFAULT = BLINK_HALF_US * 1000 / OSC_PERIOD_NS;
  localparam int BLINK_W             = 17;

  // memories and address map
  localparam int TEXT_AW  = 7;
  localparam int GLYPH_AW = 6;
  localparam int DATA_W   = 8;
  localparam logic [7:0] SPACE_CODE   = 8'h20;
  localparam logic [6:0] ADDR_ZERO    = 7'h00;
  localparam logic [6:0] ADDR_ONE     = 7'h01;
  localparam logic [6:0] TEXT_LAST    = 7'h7F;
  localparam logic [6:0] ONE_LINE_END = 7'h4F;
  localparam logic [6:0] LINE1_END    = 7'h27;
  localparam logic [6:0] LINE2_BASE   = 7'h40;
  localparam logic [6:0] LINE2_END    = 7'h67;
  localparam logic [6:0] SHIFT_LAST_2 = 7'h27;
  localparam logic [6:0] SHIFT_LAST_1 = 7'h4F;
  localparam logic [3:0] NIB_PAD      = 4'h0;

  // command identification bits
  localparam int BIT_CLEAR = 0;
  localparam int BIT_HOME  = 1;
  localparam int BIT_ENTRY = 2;
  localparam int BIT_CTRL  = 3;
  localparam int BIT_SHIFT = 4;
  localparam int BIT_FUNC  = 5;
  localparam int BIT_GLYPH = 6;
  localparam int BIT_TEXT  = 7;

  // command field positions
  localparam int ENTRY_DIR = 1;
  localparam int ENTRY_SH  = 0;
  localparam int CTRL_D    = 2;
  localparam int CTRL_C    = 1;
  localparam int CTRL_B    = 0;
  localparam int SHIFT_SC  = 3;
  localparam int SHIFT_RL  = 2;
  localparam int FUNC_DL   = 4;
  localparam int FUNC_N    = 3;
  localparam int FUNC_F    = 2;

  // reset values of the configuration bits
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_STEP_DIR  = 1'b1;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_CLEAR, CMD_HOME, CMD_ENTRY, CMD_CTRL, CMD_SHIFT,
    CMD_FUNC, CMD_GLYPH_ADDR, CMD_TEXT_ADDR, CMD_WDATA, CMD_RDATA
  } cmd_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CLEAR = 4'b0010,
    ST_FETCH = 4'b0100,
    ST_LOAD  = 4'b1000
  } state_t;

  // instruction class from the highest set bit
  function automatic cmd_t decode_cmd(input logic [7:0] b);
    if (b[BIT_TEXT])       return CMD_TEXT_ADDR;
    else if (b[BIT_GLYPH]) return CMD_GLYPH_ADDR;
    else if (b[BIT_FUNC])  return CMD_FUNC;
    else if (b[BIT_SHIFT]) return CMD_SHIFT;
    else if (b[BIT_CTRL])  return CMD_CTRL;
    else if (b[BIT_ENTRY]) return CMD_ENTRY;
    else if (b[BIT_HOME])  return CMD_HOME;
    else if (b[BIT_CLEAR]) return CMD_CLEAR;
    else                   return CMD_NONE;
  endfunction

  // busy length of each instruction class
  function automatic logic [BUSY_W-1:0] exec_ticks(input cmd_t c);
    case (c)
      CMD_CLEAR, CMD_HOME: return TICKS_LONG;
      CMD_WDATA, CMD_RDATA: return TICKS_DATA;
      default: return TICKS_CMD;
    endcase
  endfunction

endpackage

// ---- logic/char_ram.sv ----
`timescale 1ns/100ps
module char_ram #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock
  input  wire logic          clk,
  // single access port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rd_data_q;

  // write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
    rd_data_q <= mem[addr];
  end

  assign rd_data = rd_data_q;

endmodule

// ---- logic/char_lcd_instruction_decoder.sv ----
`timescale 1ns/100ps
// How it works
// - clear fills spaces, zeroes address, increments
// - return home zeroes address, undoes shift
// - entry mode sets direction and shift enable
// - direction high steps up, low steps down
// - glyph accesses step address the same way
// - only text writes with shift on shift
// - display control loads display, cursor, blink bits
// - cursor bit low hides cursor only
// - blink alternates solid block and character
// - shift command selects target and direction
// - cursor shift moves address by one
// - display shift keeps address counter
// - two-line cursor carries past 40th position
// - display shift applies to all lines
// - function set loads width, lines, font
// - glyph address loads six bits, selects glyph
// - text address loads seven bits, selects text
// - status read returns flag and address
// - data write stores byte at address
// - data read returns byte, then steps
// - flag reads high while executing
// - width low pairs two nibbles per byte
// - text address ranges follow line mode
// - first read without address set invalid
module char_lcd_instruction_decoder
  import char_lcd_pkg::*;
#(
  parameter int OSC_DIV     = OSC_DIV_DEFAULT,
  parameter int BLINK_TICKS = BLINK_TICKS_DEFAULT
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // host bus pins
  input  wire logic       reg_select,
  input  wire logic       read_not_write,
  input  wire logic       strobe,
  input  wire logic [7:0] bus_in,
  output logic      [7:0] bus_out,
  output logic            bus_oe,
  // state towards the panel side
  output logic            internal_op_flag,
  output logic      [6:0] addr_counter,
  output logic            glyph_selected,
  output logic      [6:0] display_shift,
  output logic            addr_step_dir,
  output logic            whole_shift_on,
  output logic            display_on_bit,
  output logic            cursor_on_bit,
  output logic            blink_on_bit,
  output logic            cursor_visible,
  output logic            cursor_solid,
  output logic            bus_width_sel,
  output logic            line_count_sel,
  output logic            font_height_sel
);

  logic              strobe_s1, strobe_s2, strobe_s3;
  logic              rs_s1, rs_s2, rnw_s1, rnw_s2;
  logic [7:0]        bus_s1, bus_s2;
  logic              acc_rs_q, acc_rnw_q, nib_phase_q;
  logic [7:0]        bus_hold_q;
  logic [3:0]        nib_hi_q;
  logic [7:0]        bus_out_q;
  logic              bus_oe_q;
  logic [OSC_W-1:0]  osc_div_q;
  logic              osc_tick_q;
  logic [BUSY_W-1:0] busy_cnt_q;
  logic              internal_op_flag_q;
  logic [6:0]        addr_counter_q, display_shift_q, sweep_q;
  logic              glyph_sel_q, addr_step_dir_q, whole_shift_on_q;
  logic              display_on_q, cursor_on_q, blink_on_q;
  logic              bus_width_sel_q, line_count_sel_q, font_height_sel_q;
  logic [7:0]        data_holding_q;
  state_t            state_q;
  logic [BLINK_W-1:0] blink_cnt_q;
  logic              blink_phase_q, cursor_visible_q, cursor_solid_q;
  logic              strobe_rise, strobe_fall, byte_done, status_read, accept;
  logic [7:0]        byte_full, read_word, text_wdata, text_rd, glyph_rd, ram_rdata;
  logic [3:0]        read_nib;
  logic [6:0]        text_addr;
  logic              text_we, glyph_we;
  cmd_t              cmd;

  // next address, wrapping to the ranges of the current line mode
  function automatic logic [6:0] next_addr(input logic [6:0] a, input logic up,
                                           input logic two, input logic glyph);
    logic [6:0] res;
    res = up ? a + ADDR_ONE : a - ADDR_ONE;
    if (glyph) begin
      res = {1'b0, res[GLYPH_AW-1:0]};
    end else if (two) begin
      if (up && a == LINE1_END) res = LINE2_BASE;
      else if (up && a == LINE2_END) res = ADDR_ZERO;
      else if (!up && a == ADDR_ZERO) res = LINE2_END;
      else if (!up && a == LINE2_BASE) res = LINE1_END;
    end else begin
      if (up && a == ONE_LINE_END) res = ADDR_ZERO;
      else if (!up && a == ADDR_ZERO) res = ONE_LINE_END;
    end
    return res;
  endfunction

  // next display offset, one offset shared by every line
  function automatic logic [6:0] next_shift(input logic [6:0] off, input logic left, input logic two);
    logic [6:0] last;
    last = two ? SHIFT_LAST_2 : SHIFT_LAST_1;
    if (left) return (off >= last) ? ADDR_ZERO : off + ADDR_ONE;
    else return (off == ADDR_ZERO) ? last : off - ADDR_ONE;
  endfunction

  // two-flop synchronisers on every pin, third strobe stage for edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
      rs_s1     <= 1'b0;
      rs_s2     <= 1'b0;
      rnw_s1    <= 1'b0;
      rnw_s2    <= 1'b0;
      bus_s1    <= 8'h00;
      bus_s2    <= 8'h00;
    end else begin
      strobe_s1 <= strobe;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
      rs_s1     <= reg_select;
      rs_s2     <= rs_s1;
      rnw_s1    <= read_not_write;
      rnw_s2    <= rnw_s1;
      bus_s1    <= bus_in;
      bus_s2    <= bus_s1;
    end
  end

  assign strobe_rise = strobe_s2 & ~strobe_s3;
  assign strobe_fall = strobe_s3 & ~strobe_s2;

  // select lines taken at the strobe rise, data held while strobe is high
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc_rs_q   <= 1'b0;
      acc_rnw_q  <= 1'b0;
      bus_hold_q <= 8'h00;
    end else begin
      if (strobe_rise) begin
        acc_rs_q  <= rs_s2;
        acc_rnw_q <= rnw_s2;
      end
      if (strobe_s2) begin
        bus_hold_q <= bus_s2;
      end
    end
  end

  // nibble pairing in 4-bit mode, high nibble first
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nib_phase_q <= 1'b0;
      nib_hi_q    <= NIB_PAD;
    end else if (strobe_fall && !bus_width_sel_q) begin
      nib_phase_q <= ~nib_phase_q;
      if (!nib_phase_q) begin
        nib_hi_q <= bus_hold_q[7:4];
      end
    end
  end

  // byte assembly and instruction acceptance
  assign byte_full   = bus_width_sel_q ? bus_hold_q : {nib_hi_q, bus_hold_q[7:4]};
  assign byte_done   = strobe_fall & (bus_width_sel_q | nib_phase_q);
  assign status_read = ~acc_rs_q & acc_rnw_q;
  assign cmd         = acc_rs_q ? (acc_rnw_q ? CMD_RDATA : CMD_WDATA) : decode_cmd(byte_full);
  assign accept      = byte_done & ~status_read & ~internal_op_flag_q & (state_q == ST_IDLE) & (cmd != CMD_NONE);

  // read value: status word or holding register, split into nibbles in 4-bit mode
  assign read_word = rs_s2 ? data_holding_q : {internal_op_flag_q, addr_counter_q};
  assign read_nib  = nib_phase_q ? read_word[3:0] : read_word[7:4];

  // bus drive, data loaded at the strobe rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_out_q <= 8'h00;
      bus_oe_q  <= 1'b0;
    end else begin
      bus_oe_q <= strobe_s2 & rnw_s2;
      if (strobe_rise) begin
        bus_out_q <= bus_width_sel_q ? read_word : {read_nib, NIB_PAD};
      end
    end
  end

  // internal oscillator as an enable pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_div_q  <= '0;
      osc_tick_q <= 1'b0;
    end else begin
      osc_tick_q <= (osc_div_q == OSC_W'(OSC_DIV - 1));
      osc_div_q  <= (osc_div_q == OSC_W'(OSC_DIV - 1)) ? '0 : osc_div_q + 1'b1;
    end
  end

  // busy flag held for the execution time in oscillator ticks
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_cnt_q         <= '0;
      internal_op_flag_q <= 1'b0;
    end else if (accept) begin
      busy_cnt_q         <= exec_ticks(cmd);
      internal_op_flag_q <= 1'b1;
    end else if (osc_tick_q && busy_cnt_q != '0) begin
      busy_cnt_q <= busy_cnt_q - TICKS_ONE;
      if (busy_cnt_q == TICKS_ONE) internal_op_flag_q <= 1'b0;
    end
  end

  // configuration bits
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_step_dir_q   <= RST_STEP_DIR;
      whole_shift_on_q  <= 1'b0;
      display_on_q      <= 1'b0;
      cursor_on_q       <= 1'b0;
      blink_on_q        <= 1'b0;
      bus_width_sel_q   <= RST_BUS_WIDTH;
      line_count_sel_q  <= 1'b0;
      font_height_sel_q <= 1'b0;
    end else if (accept) begin
      case (cmd)
        CMD_CLEAR: addr_step_dir_q <= 1'b1;
        CMD_ENTRY: begin
          addr_step_dir_q  <= byte_full[ENTRY_DIR];
          whole_shift_on_q <= byte_full[ENTRY_SH];
        end
        CMD_CTRL: begin
          display_on_q <= byte_full[CTRL_D];
          cursor_on_q  <= byte_full[CTRL_C];
          blink_on_q   <= byte_full[CTRL_B];
        end
        CMD_FUNC: begin
          bus_width_sel_q   <= byte_full[FUNC_DL];
          line_count_sel_q  <= byte_full[FUNC_N];
          font_height_sel_q <= byte_full[FUNC_F];
        end
        default: ;
      endcase
    end
  end

  // address counter and ram selection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_counter_q <= ADDR_ZERO;
      glyph_sel_q    <= 1'b0;
    end else if (accept) begin
      case (cmd)
        CMD_CLEAR, CMD_HOME: begin
          addr_counter_q <= ADDR_ZERO;
          glyph_sel_q    <= 1'b0;
        end
        CMD_SHIFT: begin
          if (!byte_full[SHIFT_SC]) begin
            addr_counter_q <= next_addr(addr_counter_q, byte_full[SHIFT_RL], line_count_sel_q, glyph_sel_q);
          end
        end
        CMD_GLYPH_ADDR: begin
          addr_counter_q <= {1'b0, byte_full[GLYPH_AW-1:0]};
          glyph_sel_q    <= 1'b1;
        end
        CMD_TEXT_ADDR: begin
          addr_counter_q <= byte_full[TEXT_AW-1:0];
          glyph_sel_q    <= 1'b0;
        end
        CMD_WDATA, CMD_RDATA: begin
          addr_counter_q <= next_addr(addr_counter_q, addr_step_dir_q, line_count_sel_q, glyph_sel_q);
        end
        default: ;
      endcase
    end
  end

  // display shift offset, common to all lines
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      display_shift_q <= ADDR_ZERO;
    end else if (accept) begin
      case (cmd)
        CMD_CLEAR, CMD_HOME: display_shift_q <= ADDR_ZERO;
        CMD_SHIFT: begin
          if (byte_full[SHIFT_SC]) begin
            display_shift_q <= next_shift(display_shift_q, ~byte_full[SHIFT_RL], line_count_sel_q);
          end
        end
        CMD_WDATA: begin
          if (whole_shift_on_q && !glyph_sel_q) begin
            display_shift_q <= next_shift(display_shift_q, addr_step_dir_q, line_count_sel_q);
          end
        end
        default: ;
      endcase
    end
  end

  // sequencer: space sweep after clear, ram prefetch into the holding register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q        <= ST_IDLE;
      sweep_q        <= ADDR_ZERO;
      data_holding_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          sweep_q <= ADDR_ZERO;
          if (accept) begin
            case (cmd)
              CMD_CLEAR: state_q <= ST_CLEAR;
              CMD_GLYPH_ADDR, CMD_TEXT_ADDR, CMD_RDATA: state_q <= ST_FETCH;
              CMD_SHIFT: begin
                if (!byte_full[SHIFT_SC] && !glyph_sel_q) state_q <= ST_FETCH;
              end
              default: ;
            endcase
          end
        end
        ST_CLEAR: begin
          sweep_q <= sweep_q + ADDR_ONE;
          if (sweep_q == TEXT_LAST) state_q <= ST_IDLE;
        end
        ST_FETCH: state_q <= ST_LOAD;
        ST_LOAD: begin
          data_holding_q <= ram_rdata;
          state_q        <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ram ports
  assign text_addr  = (state_q == ST_CLEAR) ? sweep_q : addr_counter_q;
  assign text_we    = (state_q == ST_CLEAR) | (accept & (cmd == CMD_WDATA) & ~glyph_sel_q);
  assign text_wdata = (state_q == ST_CLEAR) ? SPACE_CODE : byte_full;
  assign glyph_we   = accept & (cmd == CMD_WDATA) & glyph_sel_q;
  assign ram_rdata  = glyph_sel_q ? glyph_rd : text_rd;

  char_ram #(.AW(TEXT_AW), .DW(DATA_W)) text_ram (
    .clk     (ref_clk),
    .wr_en   (text_we),
    .addr    (text_addr),
    .wr_data (text_wdata),
    .rd_data (text_rd)
  );

  char_ram #(.AW(GLYPH_AW), .DW(DATA_W)) glyph_ram (
    .clk     (ref_clk),
    .wr_en   (glyph_we),
    .addr    (addr_counter_q[GLYPH_AW-1:0]),
    .wr_data (byte_full),
    .rd_data (glyph_rd)
  );

  // cursor appearance and blink phase
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      blink_cnt_q      <= '0;
      blink_phase_q    <= 1'b0;
      cursor_visible_q <= 1'b0;
      cursor_solid_q   <= 1'b0;
    end else begin
      if (osc_tick_q) begin
        blink_cnt_q <= (blink_cnt_q == BLINK_W'(BLINK_TICKS - 1)) ? '0 : blink_cnt_q + 1'b1;
        if (blink_cnt_q == BLINK_W'(BLINK_TICKS - 1)) blink_phase_q <= ~blink_phase_q;
      end
      cursor_visible_q <= display_on_q & cursor_on_q;
      cursor_solid_q   <= display_on_q & blink_on_q & blink_phase_q;
    end
  end

  // outputs
  assign bus_out          = bus_out_q;
  assign bus_oe           = bus_oe_q;
  assign internal_op_flag = internal_op_flag_q;
  assign addr_counter     = addr_counter_q;
  assign glyph_selected   = glyph_sel_q;
  assign display_shift    = display_shift_q;
  assign addr_step_dir    = addr_step_dir_q;
  assign whole_shift_on   = whole_shift_on_q;
  assign display_on_bit   = display_on_q;
  assign cursor_on_bit    = cursor_on_q;
  assign blink_on_bit     = blink_on_q;
  assign cursor_visible   = cursor_visible_q;
  assign cursor_solid     = cursor_solid_q;
  assign bus_width_sel    = bus_width_sel_q;
  assign line_count_sel   = line_count_sel_q;
  assign font_height_sel  = font_height_sel_q;

  // checks
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_CLEAR: assert property (accept && cmd == CMD_CLEAR |=>
    addr_counter_q == ADDR_ZERO && addr_step_dir_q && state_q == ST_CLEAR ##128 state_q == ST_IDLE)
    else $error("clear did not home, increment and sweep");
  AST_HOME: assert property (accept && cmd == CMD_HOME |=>
    addr_counter_q == ADDR_ZERO && display_shift_q == ADDR_ZERO && $stable(state_q))
    else $error("return home left address or shift");
  AST_ENTRY: assert property (accept && cmd == CMD_ENTRY |=>
    addr_step_dir_q == $past(byte_full[ENTRY_DIR]) && whole_shift_on_q == $past(byte_full[ENTRY_SH]))
    else $error("entry mode bits not loaded");
  AST_STEP_UP: assert property (accept && cmd == CMD_WDATA && addr_step_dir_q
    && !glyph_sel_q && addr_counter_q < LINE1_END |=> addr_counter_q == $past(addr_counter_q) + ADDR_ONE)
    else $error("text write did not step up");
  AST_GLYPH_STEP: assert property (accept && cmd == CMD_RDATA && !addr_step_dir_q
    && glyph_sel_q && addr_counter_q != ADDR_ZERO |=> addr_counter_q == $past(addr_counter_q) - ADDR_ONE)
    else $error("glyph read did not step down");
  AST_NO_SHIFT: assert property (accept && (cmd == CMD_RDATA || (cmd == CMD_WDATA && glyph_sel_q)) |=>
    $stable(display_shift_q))
    else $error("display shifted without text write");
  AST_CTRL: assert property (accept && cmd == CMD_CTRL |=>
    display_on_q == $past(byte_full[CTRL_D]) && blink_on_q == $past(byte_full[CTRL_B]) ##1
    cursor_visible_q == (display_on_q && cursor_on_q))
    else $error("display control bits wrong");
  AST_DSHIFT_AC: assert property (accept && cmd == CMD_SHIFT && byte_full[SHIFT_SC] |=>
    $stable(addr_counter_q) && !$stable(display_shift_q))
    else $error("display shift changed the address");
  AST_WRAP: assert property (accept && cmd == CMD_SHIFT && !byte_full[SHIFT_SC]
    && byte_full[SHIFT_RL] && line_count_sel_q && !glyph_sel_q && addr_counter_q == LINE1_END
    |=> addr_counter_q == LINE2_BASE)
    else $error("cursor did not carry to second line");
  AST_STATUS: assert property (strobe_rise && !rs_s2 && rnw_s2 && bus_width_sel_q |=>
    bus_out_q == {$past(internal_op_flag_q), $past(addr_counter_q)} && bus_oe_q)
    else $error("status read value wrong");
  AST_BUSY: assert property (accept |=> internal_op_flag_q && busy_cnt_q != '0
    ##0 (internal_op_flag_q == (busy_cnt_q != '0)) [*8])
    else $error("busy flag not held");
  COV_CLEAR: cover property (accept && cmd == CMD_CLEAR);
  COV_NIBBLE: cover property (byte_done && !bus_width_sel_q && accept);
  COV_READ: cover property (accept && cmd == CMD_RDATA ##[1:4] state_q == ST_LOAD);
  COV_SHIFT_WRITE: cover property (accept && cmd == CMD_WDATA && whole_shift_on_q);

endmodule

// ---- testbench/host_model.sv ----
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire logic       ref_clk,
  // pins towards the device
  output logic            reg_select,
  output logic            read_not_write,
  output logic            strobe,
  output logic      [7:0] bus_in,
  input  wire logic [7:0] bus_out
);
  initial begin
    reg_select = 1'b0;
    read_not_write = 1'b0;
    strobe = 1'b0;
    bus_in = 8'h00;
  end
  // one 8-bit strobe cycle; the data lines are left toggled afterwards
  task automatic xfer(input logic rs, input logic rnw, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    reg_select <= rs;
    read_not_write <= rnw;
    bus_in <= d;
    repeat (2) @(posedge ref_clk);
    strobe <= 1'b1;
    repeat (6) @(posedge ref_clk);
    q = bus_out;
    strobe <= 1'b0;
    repeat (6) @(posedge ref_clk);
    bus_in <= ~d;
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  import char_lcd_pkg::*;
  logic ref_clk, rst, rs, rnw, stb, dir, sh, don, con, bon, gsel, lines, font, width, flag, oe, cvis, csol;
  logic [7:0] bin, bout, q, r, d;
  logic [6:0] a, ds, shf, acnt;
  int n_fail, samples_checked, k, rd_cyc;
  logic [31:0] seed = 32'hd79e5d50;
  host_model host (.ref_clk(ref_clk), .reg_select(rs), .read_not_write(rnw), .strobe(stb), .bus_in(bin),
    .bus_out(bout));
  char_lcd_instruction_decoder #(.OSC_DIV(4), .BLINK_TICKS(4)) dut (.ref_clk(ref_clk), .rst(rst),
    .reg_select(rs), .read_not_write(rnw), .strobe(stb), .bus_in(bin), .bus_out(bout), .bus_oe(oe),
    .internal_op_flag(flag), .addr_counter(acnt), .glyph_selected(gsel), .display_shift(shf), .addr_step_dir(dir),
    .whole_shift_on(sh), .display_on_bit(don), .cursor_on_bit(con), .blink_on_bit(bon), .cursor_visible(cvis),
    .cursor_solid(csol), .bus_width_sel(width), .line_count_sel(lines), .font_height_sel(font));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [6:0] nxt(input logic [6:0] v, input logic up);
    return up ? v + 7'h01 : v - 7'h01;
  endfunction
  // poll status until idle, then half an oscillator tick
  task automatic idle;
    q = 8'hff;
    for (int i = 0; i < 300 && q[7] !== 1'b0; i++) host.xfer(1'b0, 1'b1, 8'h00, q);
    check("idle", {7'h00, q[7]}, 8'h00);
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic cmd(input logic c_rs, input logic [7:0] v);
    host.xfer(c_rs, 1'b0, v, q);
    idle();
  endtask
  task automatic stat(input logic [7:0] e);
    host.xfer(1'b0, 1'b1, 8'h00, q);
    check("status", q, e);
    check("counter", {1'b0, acnt}, {1'b0, e[6:0]});
  endtask
  // one byte as two 4-bit transfers, high nibble first, then wait out the busy time
  task automatic nib(input logic n_rs, input logic n_rnw, input logic [7:0] v, output logic [7:0] o);
    logic [7:0] h;
    host.xfer(n_rs, n_rnw, {v[7:4], 4'h0}, h);
    host.xfer(n_rs, n_rnw, {v[3:0], 4'h0}, o);
    o = {h[7:4], o[7:4]};
    repeat (64) @(posedge ref_clk);
  endtask
  // the device drives the data lines while a read strobe stands
  always @(posedge ref_clk) begin
    if (stb && rnw) begin
      rd_cyc <= rd_cyc + 1;
      if (rd_cyc == 3) check("bus drive", {7'h00, oe}, 8'h01);
    end else begin
      rd_cyc <= 0;
    end
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check("reset", {width, dir, sh, don, flag, gsel, lines, font}, 8'hc0);
    for (k = 0; k < 4; k++) begin
      r = $random(seed);
      d = $random(seed);
      cmd(1'b0, {5'b00001, r[2:0]});
      check("control", {5'h00, don, con, bon}, {5'h00, r[2:0]});
      check("cursor", {7'h00, cvis}, {7'h00, r[2] & r[1]});
      cmd(1'b0, {6'b000001, r[4], 1'b0});
      check("entry", {6'h00, dir, sh}, {6'h00, r[4], 1'b0});
      a = 7'h10 + {2'b00, r[7:3]};
      host.xfer(1'b0, 1'b0, {1'b1, a}, q);
      stat({1'b1, a});
      idle();
      cmd(1'b1, d);
      stat({1'b0, nxt(a, r[4])});
      cmd(1'b0, {1'b1, a});
      host.xfer(1'b1, 1'b1, 8'h00, q);
      check("read", q, d);
      idle();
      stat({1'b0, nxt(a, r[4])});
      a = nxt(a, r[4]);
      cmd(1'b0, {5'b00010, r[5], 2'b00});
      stat({1'b0, nxt(a, r[5])});
      ds = shf;
      cmd(1'b0, 8'h18);
      stat({1'b0, nxt(a, r[5])});
      check("dshift", {1'b0, shf}, {1'b0, ds + 7'h01});
    end
    cmd(1'b0, 8'h0f);
    check("cursor on", {7'h00, cvis}, 8'h01);
    k = 0;
    repeat (48) @(posedge ref_clk) k += csol;
    check("blink", {7'h00, k > 0 && k < 48}, 8'h01);
    cmd(1'b0, 8'h07);
    cmd(1'b0, 8'h85);
    ds = shf;
    cmd(1'b1, 8'h41);
    check("shift on write", {1'b0, shf}, {1'b0, ds + 7'h01});
    cmd(1'b0, 8'h6a);
    check("glyph sel", {7'h00, gsel}, 8'h01);
    cmd(1'b1, 8'h1f);
    stat(8'h2b);
    cmd(1'b0, 8'h05);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    idle();
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("glyph read", q, 8'h1f);
    idle();
    stat(8'h29);
    check("glyph no shift", {1'b0, shf}, {1'b0, ds + 7'h01});
    cmd(1'b0, 8'h02);
    stat(8'h00);
    check("home", {1'b0, shf}, 8'h00);
    cmd(1'b0, 8'hb0);
    cmd(1'b1, 8'h5a);
    cmd(1'b0, 8'h04);
    cmd(1'b0, 8'h01);
    stat(8'h00);
    check("clear dir", {7'h00, dir}, 8'h01);
    cmd(1'b0, 8'hb0);
    host.xfer(1'b1, 1'b1, 8'h00, q);
    check("clear fill", q, 8'h20);
    idle();
    cmd(1'b0, 8'h3c);
    check("function", {5'h00, width, lines, font}, 8'h07);
    cmd(1'b0, 8'ha7);
    cmd(1'b0, 8'h14);
    stat(8'h40);
    host.xfer(1'b0, 1'b0, 8'h2c, q);
    repeat (64) @(posedge ref_clk);
    check("width", {7'h00, width}, 8'h00);
    nib(1'b1, 1'b0, d, q);
    nib(1'b0, 1'b0, 8'hc0, q);
    nib(1'b1, 1'b1, 8'h00, q);
    check("nibble read", q, d);
    nib(1'b0, 1'b1, 8'h00, q);
    check("nibble status", q, 8'h41);
    test_done();
  end
  // cut a hang short
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
endmodule
